// ===== spectral_conversion_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - Latch 16-bit channel codes at conversion end
// - Double-buffer results so reads stay coherent
// - Group 0 gives LONG_BLUE_CHANNEL,X,Y,SHORT_BLUE_CHANNEL; 1 gives NEAR_INFRARED_CHANNEL,X,Y,Z
// - Group select is bit7, set before conversion
// - One group per conversion, full integration each
// - Conversion lasts at least 2.8 ms
// - Gain from gain register bits 1:0
// - Wait time between cycles, integration units
// - Zero calibration runs once after reset
// - Writing calibration register starts it; bit7 done
// - Interrupt pin high at end when config 0xCA and bit2 of 0xF9 set
// - Writing 0x04 clears interrupt and flag
// - Flag register reads 0x00 or 0x04
// - Writing 0x83 latches results for reading
// - One group's results per acquisition cycle
// - Completion flag bit2 is write-one-to-clear
// - Temperature: 10 bits over 0xD1 and 0xD2
// - Write 0x24 starts temperature; reads 0x84 when done
// - Multi-byte values stored high byte first
// - Sequencer timed from the master clock
module spectral_conversion_sequencer #(
   parameter int STEP_CYC = scs_pkg::STEP_CYC,
   parameter int CAL_CYC  = scs_pkg::CAL_CYC,
   parameter int TEMP_CYC = scs_pkg::TEMP_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   scl,
   input  wire logic                   sda_i,
   output logic                        sda_o,
   output logic                        sda_oe,
   output logic                        irq,
   input  wire scs_pkg::pd_in_t        pd_in,
   input  wire logic [scs_pkg::TEMP_W-1:0] temp_code,
   output logic                        integrate,
   output logic                        pd_group,
   output logic [1:0]                  pd_gain,
   output logic                        zero_cal,
   output logic                        temp_measure
);

   typedef enum {B_IDLE, B_ADDR, B_PTR, B_WDAT, B_RDAT} bus_t;
   typedef enum {S_CAL, S_IDLE, S_INT, S_WAIT} seq_t;

   bus_t             ph_r;
   seq_t             st_r;
   logic             scl_q, sda_q;
   logic             rise, fall, start, stop;
   logic [3:0]       cnt_r;
   logic             ack_r;
   logic [7:0]       sh_r, tx_r, ptr_r;
   logic             oe_r;
   logic             wr_r;
   logic [7:0]       wa_r, wd_r;
   logic [7:0]       rd_data;
   logic [7:0]       gain_r, group_r, acq_r, int_t_r, wait_r, irq_cfg_r, poll_en_r;
   logic [6:0]       zc_r;
   logic             zc_done_r, cal_pend_r;
   logic [7:0]       tcfg_r;
   logic             flag_r;
   logic             grp_r;
   logic [23:0]      tick_r;
   logic [7:0]       unit_r;
   logic             unit_end, conv_done, cal_end, latch_wr;
   scs_pkg::result_t buf_r, res_r;
   logic             temp_busy_r;
   logic [15:0]      temp_tick_r;
   logic             temp_end;
   logic [scs_pkg::TEMP_W-1:0] temp_r;

   // Bus pins are sampled once; edges judged against the previous sample
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_i;
      end
   end

   assign rise  = scl & ~scl_q;
   assign fall  = ~scl & scl_q;
   assign start = scl & scl_q & sda_q & ~sda_i;
   assign stop  = scl & scl_q & ~sda_q & sda_i;

   // Byte-wide serial slave; pointer auto-increments on every data byte
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_r  <= B_IDLE;
         cnt_r <= 4'h0;
         ack_r <= 1'b0;
         sh_r  <= 8'h00;
         tx_r  <= 8'h00;
         ptr_r <= 8'h00;
         oe_r  <= 1'b0;
         wr_r  <= 1'b0;
         wa_r  <= 8'h00;
         wd_r  <= 8'h00;
      end else begin
         wr_r <= 1'b0;
         if (start) begin
            ph_r  <= B_ADDR;
            cnt_r <= 4'h0;
            ack_r <= 1'b0;
            oe_r  <= 1'b0;
         end else if (stop) begin
            ph_r <= B_IDLE;
            oe_r <= 1'b0;
         end else if (ph_r != B_IDLE) begin
            if (rise && !ack_r && cnt_r != 4'h8) begin
               sh_r  <= {sh_r[6:0], sda_i};
               cnt_r <= cnt_r + 4'h1;
            end else if (rise && ack_r && ph_r == B_RDAT && sda_i) begin
               ph_r <= B_IDLE; // Master ended the read
            end
            if (fall) begin
               if (ack_r) begin
                  ack_r <= 1'b0;
                  cnt_r <= 4'h0;
                  oe_r  <= 1'b0;
                  if (ph_r == B_RDAT) begin
                     tx_r  <= rd_data;
                     oe_r  <= ~rd_data[7];
                     ptr_r <= ptr_r + 8'h01;
                  end
               end else if (cnt_r == 4'h8) begin
                  ack_r <= 1'b1;
                  unique case (ph_r)
                     B_ADDR: begin
                        if (sh_r[7:1] == scs_pkg::DEV_ADDR) begin
                           oe_r <= 1'b1;
                           ph_r <= sh_r[0] ? B_RDAT : B_PTR;
                        end else begin
                           ph_r <= B_IDLE;
                        end
                     end
                     B_PTR: begin
                        oe_r  <= 1'b1;
                        ptr_r <= sh_r;
                        ph_r  <= B_WDAT;
                     end
                     B_WDAT: begin
                        oe_r  <= 1'b1;
                        wr_r  <= 1'b1;
                        wa_r  <= ptr_r;
                        wd_r  <= sh_r;
                        ptr_r <= ptr_r + 8'h01;
                     end
                     B_RDAT, B_IDLE: begin
                        oe_r <= 1'b0; // Master drives its own acknowledge
                     end
                  endcase
               end else if (ph_r == B_RDAT && cnt_r != 4'h0) begin
                  tx_r <= {tx_r[6:0], 1'b0};
                  oe_r <= ~tx_r[6];
               end
            end
         end
      end
   end

   // Open drain: only ever pulls low
   assign sda_o  = 1'b0;
   assign sda_oe = oe_r;

   // Plain read/write settings
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gain_r    <= scs_pkg::REG_RST;
         group_r   <= scs_pkg::REG_RST;
         acq_r     <= scs_pkg::REG_RST;
         int_t_r   <= scs_pkg::REG_RST;
         wait_r    <= scs_pkg::REG_RST;
         irq_cfg_r <= scs_pkg::REG_RST;
         poll_en_r <= scs_pkg::REG_RST;
      end else if (wr_r) begin
         unique case (wa_r)
            scs_pkg::OFS_GAIN:    gain_r    <= wd_r;
            scs_pkg::OFS_GROUP:   group_r   <= wd_r;
            scs_pkg::OFS_ACQ:     acq_r     <= wd_r;
            scs_pkg::OFS_INT_T:   int_t_r   <= wd_r;
            scs_pkg::OFS_WAIT:    wait_r    <= wd_r;
            scs_pkg::OFS_IRQ_CFG: irq_cfg_r <= wd_r;
            scs_pkg::OFS_FLAG_EN: poll_en_r <= wd_r;
            default: ;
         endcase
      end
   end

   assign pd_gain = gain_r[1:0];

   // Calibration request and done bit; completion wins over a new write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zc_r       <= 7'h00;
         zc_done_r  <= 1'b0;
         cal_pend_r <= 1'b0;
      end else begin
         if (wr_r && wa_r == scs_pkg::OFS_ZCAL) begin
            zc_r       <= wd_r[6:0];
            zc_done_r  <= 1'b0;
            cal_pend_r <= 1'b1;
         end else if (st_r == S_IDLE && cal_pend_r) begin
            cal_pend_r <= 1'b0;
         end
         if (cal_end) begin
            zc_done_r <= 1'b1;
         end
      end
   end

   // Sequencer timed from the master clock; one unit is the least conversion
   assign unit_end  = tick_r == 24'(STEP_CYC - 1);
   assign cal_end   = st_r == S_CAL && tick_r == 24'(CAL_CYC - 1);
   assign conv_done = st_r == S_INT && unit_end && unit_r == int_t_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r   <= S_CAL;
         tick_r <= 24'h000000;
         unit_r <= 8'h00;
         grp_r  <= 1'b0;
      end else begin
         unique case (st_r)
            S_CAL: begin
               tick_r <= cal_end ? 24'h000000 : tick_r + 24'h000001;
               if (cal_end) begin
                  st_r <= S_IDLE;
               end
            end
            S_IDLE: begin
               tick_r <= 24'h000000;
               unit_r <= 8'h00;
               if (cal_pend_r) begin
                  st_r <= S_CAL;
               end else if (acq_r[1:0] == scs_pkg::ACQ_RUN) begin
                  st_r  <= S_INT;
                  grp_r <= group_r[scs_pkg::GROUP_BIT];
               end
            end
            S_INT: begin
               tick_r <= unit_end ? 24'h000000 : tick_r + 24'h000001;
               if (conv_done) begin
                  // (int_t + 1) whole units, never under one unit
                  unit_r <= 8'h00;
                  st_r   <= (wait_r != 8'h00) ? S_WAIT : S_IDLE;
               end else if (unit_end) begin
                  unit_r <= unit_r + 8'h01;
               end
            end
            S_WAIT: begin
               tick_r <= unit_end ? 24'h000000 : tick_r + 24'h000001;
               if (unit_end && unit_r == wait_r - 8'h01) begin
                  unit_r <= 8'h00;
                  st_r   <= S_IDLE;
               end else if (unit_end) begin
                  unit_r <= unit_r + 8'h01;
               end
            end
         endcase
      end
   end

   assign integrate = st_r == S_INT;
   assign zero_cal  = st_r == S_CAL;
   assign pd_group  = grp_r;

   // First stage: hidden buffer filled at each conversion end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buf_r <= '0;
      end else if (conv_done) begin
         buf_r.x <= pd_in.x;
         buf_r.y <= pd_in.y;
         buf_r.n <= grp_r ? pd_in.near_infrared_channel : pd_in.long_blue_channel;
         buf_r.z <= grp_r ? pd_in.z : pd_in.short_blue_channel;
      end
   end

   // Second stage: visible only after the host's latch command
   assign latch_wr = wr_r && wa_r == scs_pkg::OFS_ACQ && wd_r == scs_pkg::ACQ_LATCH;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         res_r <= '0;
      end else if (latch_wr) begin
         res_r <= buf_r;
      end
   end

   // Completion flag: a conversion end in the clear cycle survives
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else if (conv_done && poll_en_r[scs_pkg::FLAG_BIT]) begin
         flag_r <= 1'b1;
      end else if (wr_r && wa_r == scs_pkg::OFS_FLAG_CLR && wd_r[scs_pkg::FLAG_BIT]) begin
         flag_r <= 1'b0;
      end
   end

   assign irq = flag_r && irq_cfg_r == scs_pkg::IRQ_CFG_ON;

   // Temperature measurement on demand
   assign temp_end     = temp_busy_r && temp_tick_r == 16'(TEMP_CYC - 1);
   assign temp_measure = temp_busy_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         temp_busy_r <= 1'b0;
         temp_tick_r <= 16'h0000;
         temp_r      <= '0;
         tcfg_r      <= scs_pkg::REG_RST;
      end else begin
         temp_tick_r <= temp_busy_r ? temp_tick_r + 16'h0001 : 16'h0000;
         if (wr_r && wa_r == scs_pkg::OFS_TCFG) begin
            tcfg_r      <= wd_r;
            temp_busy_r <= wd_r == scs_pkg::TEMP_START;
            temp_tick_r <= 16'h0000;
         end else if (temp_end) begin
            temp_busy_r <= 1'b0;
            temp_r      <= temp_code;
            tcfg_r      <= scs_pkg::TEMP_DONE;
         end
      end
   end

   // Read mux; high byte at the lower offset, unmapped reads zero
   always_comb begin
      unique case (ptr_r)
         scs_pkg::OFS_RES_N_HI: rd_data = res_r.n[15:8];
         scs_pkg::OFS_RES_N_LO: rd_data = res_r.n[7:0];
         scs_pkg::OFS_RES_X_HI: rd_data = res_r.x[15:8];
         scs_pkg::OFS_RES_X_LO: rd_data = res_r.x[7:0];
         scs_pkg::OFS_RES_Y_HI: rd_data = res_r.y[15:8];
         scs_pkg::OFS_RES_Y_LO: rd_data = res_r.y[7:0];
         scs_pkg::OFS_RES_Z_HI: rd_data = res_r.z[15:8];
         scs_pkg::OFS_RES_Z_LO: rd_data = res_r.z[7:0];
         scs_pkg::OFS_GAIN:     rd_data = gain_r;
         scs_pkg::OFS_GROUP:    rd_data = group_r;
         scs_pkg::OFS_ACQ:      rd_data = acq_r;
         scs_pkg::OFS_INT_T:    rd_data = int_t_r;
         scs_pkg::OFS_WAIT:     rd_data = wait_r;
         scs_pkg::OFS_IRQ_CFG:  rd_data = irq_cfg_r;
         scs_pkg::OFS_FLAG_EN:  rd_data = poll_en_r;
         scs_pkg::OFS_ZCAL:     rd_data = {zc_done_r, zc_r};
         scs_pkg::OFS_TCFG:     rd_data = tcfg_r;
         scs_pkg::OFS_FLAG_CLR: rd_data = {5'h00, flag_r, 2'h0};
         scs_pkg::OFS_TEMP_HI:  rd_data = temp_r[9:2];
         scs_pkg::OFS_TEMP_LO:  rd_data = {6'h00, temp_r[1:0]};
         default:               rd_data = 8'h00;
      endcase
   end

   // Checking helpers: integration length and calibration history
   logic [31:0] conv_len_r;
   logic        cal_seen_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_len_r <= 32'h00000000;
         cal_seen_r <= 1'b0;
      end else begin
         conv_len_r <= (st_r == S_INT) ? conv_len_r + 32'h00000001 : 32'h00000000;
         if (cal_end) begin
            cal_seen_r <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_cal_before_conv: assert property (
      st_r == S_INT |-> cal_seen_r)
      else $error("conversion before first calibration");
   a_min_conv_time: assert property (
      conv_done |-> conv_len_r >= 32'(STEP_CYC - 1))
      else $error("conversion shorter than one unit");
   a_group_map: assert property (
      conv_done && !grp_r |=> buf_r.n == $past(pd_in.long_blue_channel) && buf_r.z == $past(pd_in.short_blue_channel))
      else $error("group 0 channel mapping wrong");
   a_flag_set: assert property (
      conv_done && poll_en_r[2] |=> flag_r && rd_data[2] | ptr_r != scs_pkg::OFS_FLAG_CLR)
      else $error("completion flag not set");
   a_flag_clear: assert property (
      wr_r && wa_r == scs_pkg::OFS_FLAG_CLR && wd_r[2] && !conv_done |=> !flag_r && !irq)
      else $error("flag not cleared by write one");
   a_irq_cause: assert property (
      $rose(irq) |-> $past(conv_done) || $past(wr_r && wa_r == scs_pkg::OFS_IRQ_CFG))
      else $error("interrupt rose without cause");
   a_latch_copy: assert property (
      latch_wr |=> res_r == $past(buf_r))
      else $error("latch did not copy buffer");
   a_latch_hold: assert property (
      !latch_wr |=> $stable(res_r))
      else $error("results changed without latch");
   a_temp_done: assert property (
      temp_end |=> tcfg_r == scs_pkg::TEMP_DONE ##1 !temp_busy_r || wr_r)
      else $error("temperature done code missing");
   a_cal_done: assert property (
      cal_end |=> zc_done_r)
      else $error("calibration done bit not set");

   c_conv_group0: cover property (conv_done && !grp_r);
   c_conv_group1: cover property (conv_done && grp_r);
   c_latch: cover property (latch_wr);
   c_temp: cover property (temp_end);
endmodule

// ===== scs_pkg.sv
package scs_pkg;
   // Serial port address (7-bit) and data widths
   localparam logic [6:0] DEV_ADDR   = 7'h49;
   localparam int         ADC_W      = 16;
   localparam int         TEMP_W     = 10;

   // Register offsets
   localparam logic [7:0] OFS_IRQ_CFG  = 8'h22;
   localparam logic [7:0] OFS_RES_N_HI = 8'h40;
   localparam logic [7:0] OFS_RES_N_LO = 8'h41;
   localparam logic [7:0] OFS_RES_X_HI = 8'h42;
   localparam logic [7:0] OFS_RES_X_LO = 8'h43;
   localparam logic [7:0] OFS_RES_Y_HI = 8'h44;
   localparam logic [7:0] OFS_RES_Y_LO = 8'h45;
   localparam logic [7:0] OFS_RES_Z_HI = 8'h46;
   localparam logic [7:0] OFS_RES_Z_LO = 8'h47;
   localparam logic [7:0] OFS_ZCAL     = 8'h50;
   localparam logic [7:0] OFS_GROUP    = 8'h51;
   localparam logic [7:0] OFS_ACQ      = 8'h52;
   localparam logic [7:0] OFS_INT_T    = 8'h53;
   localparam logic [7:0] OFS_WAIT     = 8'h54;
   localparam logic [7:0] OFS_TCFG     = 8'h55;
   localparam logic [7:0] OFS_GAIN     = 8'hB9;
   localparam logic [7:0] OFS_TEMP_HI  = 8'hD1;
   localparam logic [7:0] OFS_TEMP_LO  = 8'hD2;
   localparam logic [7:0] OFS_FLAG_CLR = 8'hF8;
   localparam logic [7:0] OFS_FLAG_EN  = 8'hF9;

   // Field positions, command codes and reset value
   localparam int         FLAG_BIT    = 2;
   localparam int         GROUP_BIT   = 7;
   localparam logic [7:0] REG_RST     = 8'h00;
   localparam logic [7:0] ACQ_LATCH   = 8'h83;
   localparam logic [1:0] ACQ_RUN     = 2'h3;
   localparam logic [7:0] IRQ_CFG_ON  = 8'hCA;
   localparam logic [7:0] TEMP_START  = 8'h24;
   localparam logic [7:0] TEMP_DONE   = 8'h84;

   // Timing: one integration unit is the least conversion time
   localparam real        CLK_PERIOD_NS = 4.0;
   localparam real        MIN_CONV_MS   = 2.8;
   localparam int STEP_CYC = int'($ceil(MIN_CONV_MS * 1.0E6 / CLK_PERIOD_NS));
   localparam int CAL_CYC  = 64;
   localparam int TEMP_CYC = 64;

   // Six raw photodiode channels from the analog front end
   typedef struct packed {
      logic [ADC_W-1:0] near_infrared_channel;
      logic [ADC_W-1:0] x;
      logic [ADC_W-1:0] y;
      logic [ADC_W-1:0] z;
      logic [ADC_W-1:0] short_blue_channel;
      logic [ADC_W-1:0] long_blue_channel;
   } pd_in_t;

   // The four result pairs
   typedef struct packed {
      logic [ADC_W-1:0] n;
      logic [ADC_W-1:0] x;
      logic [ADC_W-1:0] y;
      logic [ADC_W-1:0] z;
   } result_t;
endpackage

// ===== i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // A quarter of a sent bit, a third of a received one; slow so the oversampled slave sees every level
   task automatic pin(input logic s, input logic l);
      scl = s;
      sda_low = l;
      repeat (4) @(negedge clk);
   endtask
   // Start and repeated start; data falls while the clock is high
   task automatic start();
      pin(0, 0);
      pin(1, 0);
      pin(1, 1);
      pin(0, 1);
   endtask
   task automatic stop();
      pin(0, 1);
      pin(1, 1);
      pin(1, 0);
   endtask
   // Data only moves while the clock is low, never at its fall
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         pin(0, ~b[i]);
         pin(1, ~b[i]);
         pin(1, ~b[i]);
         pin(0, ~b[i]);
      end
      pin(0, 0);
      pin(1, 0);
      ack = ~sda;
      pin(0, 0);
   endtask
   task automatic recv(output logic [7:0] b, input logic nack);
      for (int i = 7; i >= 0; i--) begin
         pin(0, 0);
         pin(1, 0);
         b[i] = sda;
         pin(0, 0);
      end
      pin(0, ~nack);
      pin(1, ~nack);
      pin(0, ~nack);
   endtask
   task automatic probe(input logic [7:0] a, output logic ack);
      start();
      send(a, ack);
      stop();
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic k1, k2, k3;
      start();
      send({scs_pkg::DEV_ADDR, 1'b0}, k1);
      send(a, k2);
      send(d, k3);
      stop();
      ok = k1 & k2 & k3;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic k1, k2, k3;
      start();
      send({scs_pkg::DEV_ADDR, 1'b0}, k1);
      send(a, k2);
      start();
      send({scs_pkg::DEV_ADDR, 1'b1}, k3);
      recv(d, 1'b1);
      stop();
      ok = k1 & k2 & k3;
   endtask
   // Start sequence; enabling first lets the flag set at all
   task automatic arm(output logic ok);
      logic k1, k2, k3, k4;
      write_reg(scs_pkg::OFS_FLAG_EN, 8'h04, k1);
      write_reg(scs_pkg::OFS_ACQ, 8'h01, k2);
      write_reg(scs_pkg::OFS_FLAG_CLR, 8'h04, k3);
      write_reg(scs_pkg::OFS_ACQ, 8'h03, k4);
      ok = k1 & k2 & k3 & k4;
   endtask
endmodule

// ===== spectral_conversion_sequencer_tb.sv
`timescale 1ns/1ps
module spectral_conversion_sequencer_tb;
   localparam int STEP = 20;
   logic                       clk, rst, scl, sda, sda_low, sda_o, sda_oe, irq;
   logic                       integrate, pd_group, zero_cal, temp_measure;
   logic [1:0]                 pd_gain;
   scs_pkg::pd_in_t            pd_in;
   logic [scs_pkg::TEMP_W-1:0] temp_code;
   int                         bad_count = 0, num_checks = 0, cycles = 0;
   int                         hi_run = 0, lo_run = 0, hi_last = 0, gap_last = 0, zc_rises = 0;
   logic                       zc_q = 1'b0;

   // Pulled-up data line, low when either side pulls it
   assign sda = (sda_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

   // Master clock of the sequencer
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   spectral_conversion_sequencer #(.STEP_CYC(STEP), .CAL_CYC(8), .TEMP_CYC(8)) DUT (
      .clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .irq(irq), .pd_in(pd_in), .temp_code(temp_code), .integrate(integrate),
      .pd_group(pd_group), .pd_gain(pd_gain), .zero_cal(zero_cal),
      .temp_measure(temp_measure));

   i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

   // Run lengths of integration and idle, and calibration starts
   always @(posedge clk) begin
      zc_q <= zero_cal;
      if (zero_cal === 1'b1 && zc_q === 1'b0) zc_rises++;
      if (integrate === 1'b1) begin
         if (hi_run == 0) gap_last = lo_run;
         hi_run++;
         lo_run = 0;
      end else begin
         if (hi_run != 0) hi_last = hi_run;
         lo_run++;
         hi_run = 0;
      end
   end

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      host.write_reg(a, d, ok);
      chk(ok, 1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic ok;
      host.read_reg(a, d, ok);
      chk(ok, 1);
   endtask
   // Bounded polling; the last value read is judged
   task automatic poll(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      int n;
      n = 0;
      do begin
         rd(a, d);
         n++;
      end while (d !== exp && n < 40);
      chk(d, exp);
   endtask

   // Registers come up cleared and the first calibration has run
   task automatic t_reset();
      logic [7:0] d;
      logic [7:0] ofs[8] = '{8'h22, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'hB9, 8'hF9};
      repeat (12) @(negedge clk);
      chk(zero_cal, 0);
      rd(scs_pkg::OFS_ZCAL, d);
      chk(d, 8'h80);
      foreach (ofs[i]) begin
         rd(ofs[i], d);
         chk(d, 8'h00);
      end
   endtask

   // Full conversion, latch and clear, then a second unlatched result
   task automatic t_conv(input logic grp, input logic [7:0] wt);
      logic [7:0] d;
      logic [63:0] exp;
      logic ok;
      pd_in = {16'h1A1B, 16'h2C2D, 16'h3E3F, 16'h4A4B, 16'h5C5D, 16'h6E6F} ^ {6{{15'h0, grp}}};
      exp = grp ? {pd_in.near_infrared_channel, pd_in.x, pd_in.y, pd_in.z} : {pd_in.long_blue_channel, pd_in.x, pd_in.y, pd_in.short_blue_channel};
      wr(scs_pkg::OFS_GROUP, {grp, 7'h00});
      wr(scs_pkg::OFS_GAIN, {6'h00, grp, ~grp});
      chk(pd_gain, {grp, ~grp});
      wr(scs_pkg::OFS_INT_T, 8'h3F);
      wr(scs_pkg::OFS_WAIT, wt);
      wr(scs_pkg::OFS_IRQ_CFG, 8'hCA);
      host.arm(ok);
      chk(ok, 1);
      repeat (3) @(negedge clk);
      chk({integrate, pd_group}, {1'b1, grp});
      rd(scs_pkg::OFS_FLAG_CLR, d);
      chk({d, 7'h00, irq}, 16'h0000);
      poll(scs_pkg::OFS_FLAG_CLR, 8'h04);
      chk(irq, 1);
      chk(16'(hi_last >= 64 * STEP), 1);
      wr(scs_pkg::OFS_ACQ, 8'h83);
      for (int i = 0; i < 8; i++) begin
         rd(8'(scs_pkg::OFS_RES_N_HI + i), d);
         chk(d, exp[63 - 8 * i -: 8]);
      end
      wr(scs_pkg::OFS_FLAG_CLR, 8'h04);
      chk(irq, 0);
      pd_in = ~pd_in;
      poll(scs_pkg::OFS_FLAG_CLR, 8'h04);
      chk(16'(gap_last >= wt * STEP), 1);
      rd(scs_pkg::OFS_RES_N_HI, d);
      chk(d, exp[63:56]);
      wr(scs_pkg::OFS_ACQ, 8'h00);
      wr(scs_pkg::OFS_FLAG_CLR, 8'h04);
   endtask

   // Host-requested calibration after a temperature reading
   task automatic t_zcal();
      int n0;
      n0 = zc_rises;
      wr(scs_pkg::OFS_ZCAL, 8'h00);
      poll(scs_pkg::OFS_ZCAL, 8'h80);
      chk(16'(zc_rises - n0), 1);
   endtask

   // Temperature measurement, split result, read-only byte
   task automatic t_temp();
      logic [7:0] d;
      temp_code = 10'h2A5;
      wr(scs_pkg::OFS_TCFG, 8'h24);
      poll(scs_pkg::OFS_TCFG, 8'h84);
      wr(scs_pkg::OFS_TEMP_HI, 8'h5A);
      rd(scs_pkg::OFS_TEMP_HI, d);
      chk(d, temp_code[9:2]);
      rd(scs_pkg::OFS_TEMP_LO, d);
      chk(d, {6'h00, temp_code[1:0]});
      wr(scs_pkg::OFS_TCFG, 8'h00);
      rd(scs_pkg::OFS_TCFG, d);
      chk(d, 8'h00);
   endtask

   // Foreign address is ignored, unmapped offset reads zero
   task automatic t_refuse();
      logic [7:0] d;
      logic ack;
      host.probe(8'h94, ack);
      chk({ack, sda_oe}, 0);
      rd(8'h30, d);
      chk(d, 8'h00);
   endtask

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      pd_in = '0;
      temp_code = '0;
      repeat (4) @(negedge clk);
      chk(zero_cal, 1);
      rst = 1'b0;
      t_reset();
      t_conv(1'b0, 8'h00);
      t_conv(1'b1, 8'h02);
      t_temp();
      t_zcal();
      t_refuse();
      print_verdict();
   end
endmodule
